// File: design/swr_pkg.sv
// shared constants and types for the supervisor watchdog
package swr_pkg;
	// system clock
	localparam int CLK_HZ = 50_000_000;
	// internal oscillator rate and the clk cycles per oscillator cycle
	localparam int INT_OSC_HZ    = 10240;
	localparam int INT_DIV_CYCLES = CLK_HZ / INT_OSC_HZ;
	// nominal times on the internal oscillator
	localparam int SHORT_MS   = 100;
	localparam int LONG_MS    = 1600;
	localparam int RST_MS     = 200;
	localparam int INT_SHORT  = SHORT_MS * INT_OSC_HZ / 1000;
	localparam int INT_LONG   = LONG_MS * INT_OSC_HZ / 1000;
	localparam int INT_RST    = RST_MS * INT_OSC_HZ / 1000;
	// timebase cycle counts on an external clock
	localparam int EXT_SHORT  = 1024;
	localparam int EXT_LONG   = 4096;
	localparam int EXT_RST    = 2048;
	// counter width and terminal counts (count value on the last cycle)
	localparam int CNT_W      = 15;
	localparam logic [CNT_W-1:0] INT_SHORT_LAST = CNT_W'(INT_SHORT - 1);
	localparam logic [CNT_W-1:0] INT_LONG_LAST  = CNT_W'(INT_LONG - 1);
	localparam logic [CNT_W-1:0] INT_RST_LAST   = CNT_W'(INT_RST - 1);
	localparam logic [CNT_W-1:0] EXT_SHORT_LAST = CNT_W'(EXT_SHORT - 1);
	localparam logic [CNT_W-1:0] EXT_LONG_LAST  = CNT_W'(EXT_LONG - 1);
	localparam logic [CNT_W-1:0] EXT_RST_LAST   = CNT_W'(EXT_RST - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO       = 15'h0000;
	// width of the pin bundle that crosses into clk
	localparam int PIN_W = 5;

	// asynchronous pins, sampled through two flops
	typedef struct packed {
		logic kick;
		logic kick_float;
		logic src_sel;
		logic tb_in;
		logic supply_ok;
	} swr_pins_t;

	// watchdog phases
	typedef enum logic [1:0] {
		SWR_WATCH = 2'b01,
		SWR_RESET = 2'b10
	} swr_state_t;
endpackage

// File: design/swr_timebase.sv
// timebase tick generator: internal oscillator divider or external clock edges
`timescale 1ns/100ps
module swr_timebase #(
	parameter int DIV = swr_pkg::INT_DIV_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// source choice and synchronised external clock level
	input  wire logic use_ext,
	input  wire logic ext_lvl,
	// one-cycle timebase pulse
	output logic      tick
);
	logic [31:0] div_q;
	logic        ext_prev_q;
	logic        tick_q;

	assign tick = tick_q;

	// internal oscillator divider
	always_ff @(posedge clk) begin
		if (rst || use_ext || div_q == 32'(DIV - 1)) begin
			div_q <= 32'h00000000;
		end else begin
			div_q <= div_q + 32'h00000001;
		end
	end

	// previous external level for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_lvl;
		end
	end

	// tick from rising external edge or divider wrap
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q <= 1'b0;
		end else if (use_ext) begin
			tick_q <= ext_lvl && !ext_prev_q;
		end else begin
			tick_q <= (div_q == 32'(DIV - 1));
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	tick_single_a: assert property (tick |=> !tick) else $error("tick longer than one cycle");
	int_period_a: assert property (!use_ext && tick |-> div_q == 32'h00000000)
		else $error("internal tick off the divider wrap");
endmodule

// File: design/swr_watchdog.sv
// watchdog timer and reset pulse generator
`timescale 1ns/100ps
// Notes on behaviour
// - on expiry drive reset low for the reset active time
// - after each reset use the long timeout
// - switch to short timeout only after first kick edge after reset release
// - restart the timeout count as reset goes inactive
// - any kick edge before expiry clears the timer; host must kick in time
// - a stuck kick input gives periodic resets, every long timeout
// - a floating kick input disables the watchdog
// - invalid main supply disables the watchdog
// - timeout flag goes low on expiry, high again on next kick edge
// - timeout flag forced high while main supply is invalid
// - external clock: 1024 short, 4096 long, 2048 reset cycles
// - select high or floating: internal oscillator, fixed reset time
// - internal: input low 100ms, high 1.6s short; long 1.6s; reset 200ms
// - internal oscillator 10.24kHz, all internal times counted in its cycles
module swr_watchdog #(
	parameter int INT_DIV = swr_pkg::INT_DIV_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// processor kick and its float detector
	input  wire logic watchdog_kick_in,
	input  wire logic watchdog_kick_float,
	// timebase pins (floating reads high)
	input  wire logic timebase_source_select,
	input  wire logic timebase_input,
	// supply above reset threshold and above backup battery
	input  wire logic supply_ok,
	// outputs
	output logic      reset_n,
	output logic      watchdog_timeout_flag_out
);
	logic [swr_pkg::PIN_W-1:0] sync1_q;
	logic [swr_pkg::PIN_W-1:0] sync2_q;
	swr_pkg::swr_pins_t        raw;
	swr_pkg::swr_pins_t        pin;
	swr_pkg::swr_state_t       state_q;
	logic [swr_pkg::CNT_W-1:0] cnt_q;
	logic [swr_pkg::CNT_W-1:0] wd_last;
	logic [swr_pkg::CNT_W-1:0] rst_last;
	logic                      kick_prev_q;
	logic                      long_q;
	logic                      reset_n_q;
	logic                      flag_q;
	logic                      tick;
	logic                      use_ext;
	logic                      enable;
	logic                      kick_edge;
	logic [swr_pkg::CNT_W-1:0] low_ticks_q;

	assign raw.kick       = watchdog_kick_in;
	assign raw.kick_float = watchdog_kick_float;
	assign raw.src_sel    = timebase_source_select;
	assign raw.tb_in      = timebase_input;
	assign raw.supply_ok  = supply_ok;
	assign pin            = sync2_q;
	assign reset_n                   = reset_n_q;
	assign watchdog_timeout_flag_out = flag_q;

	// two-flop synchronisers, one per pin
	for (genvar i = 0; i < swr_pkg::PIN_W; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (rst) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= raw[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end

	// source and enable decode
	assign use_ext   = !pin.src_sel;
	assign enable    = pin.supply_ok && !pin.kick_float;
	assign kick_edge = pin.kick != kick_prev_q;

	// terminal counts for the selected timebase
	always_comb begin
		if (use_ext) begin
			wd_last  = long_q ? swr_pkg::EXT_LONG_LAST : swr_pkg::EXT_SHORT_LAST;
			rst_last = swr_pkg::EXT_RST_LAST;
		end else begin
			wd_last  = (long_q || pin.tb_in) ? swr_pkg::INT_LONG_LAST : swr_pkg::INT_SHORT_LAST;
			rst_last = swr_pkg::INT_RST_LAST;
		end
	end

	swr_timebase #(
		.DIV (INT_DIV)
	) u_timebase (
		.clk     (clk),
		.rst     (rst),
		.use_ext (use_ext),
		.ext_lvl (pin.tb_in),
		.tick    (tick)
	);

	// previous kick sample
	always_ff @(posedge clk) begin
		if (rst) begin
			kick_prev_q <= 1'b0;
		end else begin
			kick_prev_q <= pin.kick;
		end
	end

	// watchdog sequencer and counter
	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			state_q   <= swr_pkg::SWR_WATCH;
			cnt_q     <= swr_pkg::CNT_ZERO;
			reset_n_q <= 1'b1;
		end else begin
			unique case (state_q)
				swr_pkg::SWR_WATCH: begin
					if (kick_edge) begin
						cnt_q <= swr_pkg::CNT_ZERO;
					end else if (tick && cnt_q == wd_last) begin
						state_q   <= swr_pkg::SWR_RESET;
						cnt_q     <= swr_pkg::CNT_ZERO;
						reset_n_q <= 1'b0;
					end else if (tick) begin
						cnt_q <= cnt_q + 15'h0001;
					end
				end
				swr_pkg::SWR_RESET: begin
					if (tick && cnt_q == rst_last) begin
						state_q   <= swr_pkg::SWR_WATCH;
						cnt_q     <= swr_pkg::CNT_ZERO;
						reset_n_q <= 1'b1;
					end else if (tick) begin
						cnt_q <= cnt_q + 15'h0001;
					end
				end
			endcase
		end
	end

	// long timeout after reset until the first kick
	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			long_q <= 1'b1;
		end else if (state_q == swr_pkg::SWR_RESET) begin
			long_q <= 1'b1;
		end else if (kick_edge) begin
			long_q <= 1'b0;
		end
	end

	// timeout flag: low on expiry, high on kick or bad supply
	always_ff @(posedge clk) begin
		if (rst || !pin.supply_ok) begin
			flag_q <= 1'b1;
		end else if (kick_edge) begin
			flag_q <= 1'b1;
		end else if (enable && state_q == swr_pkg::SWR_WATCH && tick && cnt_q == wd_last) begin
			flag_q <= 1'b0;
		end
	end

	// ticks seen while reset is low, for the pulse length check
	always_ff @(posedge clk) begin
		if (rst || reset_n_q) begin
			low_ticks_q <= swr_pkg::CNT_ZERO;
		end else if (tick) begin
			low_ticks_q <= low_ticks_q + 15'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// expiry and reset pulse; a disable may end the pulse early
	expire_reset_a: assert property (enable && state_q == swr_pkg::SWR_WATCH
		&& tick && cnt_q == wd_last && !kick_edge |=> !reset_n_q && !flag_q)
		else $error("expiry did not assert reset");
	reset_hold_a: assert property (!reset_n_q && enable && !(tick && cnt_q == rst_last)
		|=> !reset_n_q) else $error("reset pulse ended early");
	reset_len_a: assert property ($rose(reset_n_q) && $past(enable)
		|-> $past(low_ticks_q) == $past(rst_last)) else $error("reset pulse length wrong");
	kick_ignore_a: assert property (enable && state_q == swr_pkg::SWR_RESET && kick_edge
		&& !(tick && cnt_q == rst_last) |=> !reset_n_q) else $error("kick cut the reset pulse");
	release_long_a: assert property ($rose(reset_n_q)
		|-> cnt_q == swr_pkg::CNT_ZERO && long_q) else $error("release without restart or long timeout");
	long_reset_a: assert property (state_q == swr_pkg::SWR_RESET |=> long_q)
		else $error("no long timeout after reset");

	// kicks and timeout length
	short_switch_a: assert property (enable && kick_edge && state_q == swr_pkg::SWR_WATCH
		|=> !long_q) else $error("no switch to short timeout");
	kick_restart_a: assert property (enable && kick_edge && state_q == swr_pkg::SWR_WATCH
		|=> cnt_q == swr_pkg::CNT_ZERO && reset_n_q) else $error("kick did not clear timer");
	int_short_a: assert property (!use_ext && !long_q && !pin.tb_in
		|-> wd_last == swr_pkg::INT_SHORT_LAST) else $error("wrong internal short timeout");
	int_long_a: assert property (!use_ext && pin.tb_in
		|-> wd_last == swr_pkg::INT_LONG_LAST && rst_last == swr_pkg::INT_RST_LAST)
		else $error("wrong internal long counts");
	ext_long_a: assert property (use_ext && long_q
		|-> wd_last == swr_pkg::EXT_LONG_LAST && rst_last == swr_pkg::EXT_RST_LAST)
		else $error("wrong external counts");
	ext_short_a: assert property (use_ext && !long_q |-> wd_last == swr_pkg::EXT_SHORT_LAST)
		else $error("wrong external short timeout");

	// disable paths and timeout flag
	disable_clear_a: assert property (!enable |=> cnt_q == swr_pkg::CNT_ZERO && reset_n_q)
		else $error("watchdog active while disabled");
	float_off_a: assert property (pin.kick_float |=> cnt_q == swr_pkg::CNT_ZERO && reset_n_q)
		else $error("watchdog active with floating kick");
	flag_forced_a: assert property (!pin.supply_ok |=> flag_q)
		else $error("flag low with bad supply");
	flag_kick_a: assert property (kick_edge |=> flag_q) else $error("kick did not raise flag");
	flag_hold_a: assert property (!flag_q && pin.supply_ok && !kick_edge |=> !flag_q)
		else $error("flag rose without a kick");

	expire_c: cover property ($fell(reset_n_q));
	release_c: cover property ($rose(reset_n_q));
	kick_c: cover property (enable && kick_edge && !long_q);
	int_long_c: cover property (enable && !use_ext && pin.tb_in && tick);
	float_c: cover property (pin.kick_float && kick_edge);
endmodule

// File: dv/swr_host_model.sv
// processor model that services the watchdog kick pin
`timescale 1ns/100ps
module swr_host_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// service control from the bench
	input  wire logic        active,
	input  wire logic        poke,
	input  wire logic        release_pin,
	input  wire logic [15:0] gap,
	// kick pin
	output logic             kick
);
	logic [15:0] wait_q;
	logic        rel_q;

	// toggle on demand or when the service gap runs out
	always_ff @(posedge clk) begin
		rel_q <= release_pin;
		if (rst) begin
			kick   <= 1'b0;
			wait_q <= 16'h0000;
		end else if (release_pin != rel_q) begin
			kick   <= ~kick; // released pad shows the inverse level
			wait_q <= 16'h0000;
		end else if (poke || (active && wait_q >= gap)) begin
			kick   <= ~kick;
			wait_q <= 16'h0000;
		end else begin
			wait_q <= wait_q + 16'h0001;
		end
	end
endmodule

// File: dv/testbench.sv
// self-checking bench for the supervisor watchdog
`timescale 1ns/100ps
module testbench;
	localparam int DIV = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        kick_float = 1'b0;
	logic        src_sel = 1'b0;
	logic        tb_in = 1'b0;
	logic        supply_ok = 1'b1;
	logic        active = 1'b0;
	logic        poke = 1'b0;
	logic        release_pin = 1'b0;
	logic [15:0] gap = 16'h0100;
	logic        kick;
	logic        reset_n;
	logic        flag;
	int          err_count = 0;
	int          check_count = 0;
	int          seed = 32'h59bc;
	bit          m_long = 1'b1;

	// 50 MHz clock
	always #10 clk = ~clk;

	swr_watchdog #(.INT_DIV(DIV)) i_dut (
		.clk(clk), .rst(rst), .watchdog_kick_in(kick), .watchdog_kick_float(kick_float),
		.timebase_source_select(src_sel), .timebase_input(tb_in), .supply_ok(supply_ok),
		.reset_n(reset_n), .watchdog_timeout_flag_out(flag));

	swr_host_model i_host (
		.clk(clk), .rst(rst), .active(active), .poke(poke), .release_pin(release_pin),
		.gap(gap), .kick(kick));

	// model of the timeout length in timebase ticks
	function automatic int timeout_len();
		if (!src_sel)
			return m_long ? swr_pkg::EXT_LONG : swr_pkg::EXT_SHORT;
		return (m_long || tb_in) ? swr_pkg::INT_LONG : swr_pkg::INT_SHORT;
	endfunction

	function automatic int rst_len();
		return src_sel ? swr_pkg::INT_RST : swr_pkg::EXT_RST;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input int tol);
		check_count++;
		if ($isunknown(got) || !(got === exp || (tol > 0 && got >= exp - tol && got <= exp + tol))) begin
			err_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one timebase tick: external clock edge or internal divider span
	task automatic tick();
		if (!src_sel) begin
			@(posedge clk) tb_in <= 1'b1;
			@(posedge clk) tb_in <= 1'b0;
		end else begin
			repeat (DIV) @(posedge clk);
		end
	endtask

	// count ticks until reset output reaches lvl
	task automatic measure(input int len, input logic lvl);
		int n;
		n = 0;
		while (reset_n !== lvl && n < len + 8) begin
			tick();
			n++;
		end
		if (!lvl)
			m_long = 1'b1;
		check(16'(n), 16'(len), 4);
	endtask

	// run ticks with random service gaps, no reset allowed
	task automatic quiet(input int len);
		int lows;
		lows = 0;
		repeat (len) begin
			gap <= 16'(200 + $unsigned($random(seed)) % 1200);
			tick();
			if (reset_n !== 1'b1)
				lows++;
		end
		check(16'(lows), 16'h0000, 0);
	endtask

	task automatic kick_now();
		poke <= 1'b1;
		@(posedge clk) poke <= 1'b0;
		m_long = 1'b0;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#1_900_000; // about 95000 cycles, the sequence needs some 79000
		err_count++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		measure(timeout_len(), 1'b0);
		check(16'(flag), 16'h0000, 0);
		measure(rst_len(), 1'b1);
		measure(timeout_len(), 1'b0);
		measure(rst_len(), 1'b1);
		kick_now();
		active <= 1'b1;
		quiet(2500);
		check(16'(flag), 16'h0001, 0);
		active <= 1'b0;
		kick_now();
		measure(timeout_len(), 1'b0);
		supply_ok <= 1'b0;
		repeat (6) @(posedge clk);
		check(16'(flag), 16'h0001, 0);
		quiet(timeout_len() + 200);
		supply_ok <= 1'b1;
		measure(timeout_len(), 1'b0);
		measure(rst_len(), 1'b1);
		kick_float <= 1'b1;
		release_pin <= 1'b1;
		quiet(timeout_len() + 200);
		kick_float <= 1'b0;
		release_pin <= 1'b0;
		src_sel <= 1'b1;
		tb_in <= 1'b0;
		repeat (4) @(posedge clk);
		kick_now();
		measure(timeout_len(), 1'b0);
		measure(rst_len(), 1'b1);
		// internal oscillator with the input high: no expiry at the 100ms count
		tb_in <= 1'b1;
		kick_now();
		quiet(swr_pkg::INT_SHORT + 200);
		complete_run();
	end
endmodule
